// ===== rtl/drv_spi_pkg.sv
// constants shared by both ends of the driver command/status link
package drv_spi_pkg;
   // ----------------------------------------
   // link and timing
   // ----------------------------------------
   localparam int WORD_BITS = 16;
   localparam int CLK_NS = 100;
   localparam int STR_NS = 1000;
   localparam int STR_CYC = (STR_NS + CLK_NS - 1) / CLK_NS;
   localparam int SHORT_MIN_US = 30;
   localparam int SHORT_STEPS = 32;
   localparam int OPEN_OFF_US = 200;
   localparam int OPEN_OFF_CYC = OPEN_OFF_US * 1000 / CLK_NS;
   localparam int SHORT_MIN_CYC = SHORT_MIN_US * 1000 / CLK_NS;
   localparam int RETRY_PERIOD_CYC = 10000;
   localparam int RETRY_ON_CYC = RETRY_PERIOD_CYC / 100;
   localparam int HALF_SCLK_CYC = 4;
   // ----------------------------------------
   // controller registers (byte offsets)
   // ----------------------------------------
   localparam logic [31:0] REG_TX = 32'h0000_0000;
   localparam logic [31:0] REG_RX = 32'h0000_0004;
   localparam logic [31:0] REG_CTRL = 32'h0000_0008;
   localparam logic [31:0] REG_STAT = 32'h0000_000C;
   localparam logic [31:0] REG_MASK = 32'h0000_0010;
   localparam logic [15:0] TX_RESET = 16'h0000;
   localparam logic [1:0] MASK_RESET = 2'b00;
   localparam int CTRL_GO_BIT = 0;
   localparam int ST_DONE_BIT = 0;
   localparam int ST_FAULT_BIT = 1;
endpackage

// ===== rtl/drv_spi_if.sv
// pins of the four-wire link between controller and driver
`timescale 1ns/1ps
interface drv_spi_if;
   logic cs_n;
   logic sclk;
   logic si;
   logic so_o;
   logic so_oe;
   logic so;
   assign so = so_oe ? so_o : 1'b1;
   modport host (output cs_n, output sclk, output si, input so);
   modport device (input cs_n, input sclk, input si, output so_o, output so_oe);
endinterface

// ===== rtl/drv_spi_device.sv
// driver end: shift register, command latch, fault filters and gate limiter
`timescale 1ns/1ps
module drv_spi_device #(
   parameter int CHANNELS = 8,
   parameter int OPEN_OFF_CYC = drv_spi_pkg::OPEN_OFF_CYC,
   parameter int RETRY_PERIOD_CYC = drv_spi_pkg::RETRY_PERIOD_CYC
) (
   input wire logic hclk,
   input wire logic hresetn,
   drv_spi_if.device link,
   input wire logic [CHANNELS-1:0] short_raw,
   input wire logic [CHANNELS-1:0] open_raw,
   input wire logic [4:0] filter_sel,
   output logic [CHANNELS-1:0] drive_on,
   output logic [CHANNELS-1:0] fault
);
   localparam int W = drv_spi_pkg::WORD_BITS;
   localparam int RON = RETRY_PERIOD_CYC / 100;
   // ----------------------------------------
   // pin synchronisers
   // ----------------------------------------
   logic [2:0] cs_s_q, sck_s_q;
   logic [1:0] si_s_q;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cs_s_q <= 3'b111;
         sck_s_q <= 3'b000;
         si_s_q <= 2'b00;
      end else begin
         cs_s_q <= {cs_s_q[1:0], link.cs_n};
         sck_s_q <= {sck_s_q[1:0], link.sclk};
         si_s_q <= {si_s_q[0], link.si};
      end
   end
   // fault comparators run free of hclk, so they are synchronised too
   logic [CHANNELS-1:0] short_s1_q, short_s2_q, open_s1_q, open_s2_q;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         short_s1_q <= '0;
         short_s2_q <= '0;
         open_s1_q <= '0;
         open_s2_q <= '0;
      end else begin
         short_s1_q <= short_raw;
         short_s2_q <= short_s1_q;
         open_s1_q <= open_raw;
         open_s2_q <= open_s1_q;
      end
   end
   wire sel = !cs_s_q[1];
   wire cs_fall = cs_s_q[2] && !cs_s_q[1];
   wire cs_rise = !cs_s_q[2] && cs_s_q[1];
   wire sck_rise = sel && !sck_s_q[2] && sck_s_q[1];
   wire sck_fall = sel && sck_s_q[2] && !sck_s_q[1];
   // ----------------------------------------
   // shift path
   // ----------------------------------------
   logic [W-1:0] rx_q, tx_q, cmd_q;
   logic so_q, oe_q;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rx_q <= '0;
      end else if (sck_rise) begin
         rx_q <= {rx_q[W-2:0], si_s_q[1]};
      end
   end
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         tx_q <= '0;
         so_q <= 1'b0;
      end else if (cs_fall) begin
         // status word: one bit per channel, upper bits zero
         tx_q <= W'(fault) << 1;
         so_q <= fault[CHANNELS-1] && (CHANNELS == W);
      end else if (sck_fall) begin
         // received bits follow the status, so long frames pass through
         so_q <= tx_q[W-1];
         tx_q <= {tx_q[W-2:0], rx_q[W-1]};
      end
   end
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         oe_q <= 1'b0;
      end else if (cs_fall) begin
         oe_q <= 1'b1;
      end else if (cs_rise || !sel) begin
         oe_q <= 1'b0;
      end
   end
   assign link.so_o = so_q;
   assign link.so_oe = oe_q;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cmd_q <= '0;
      end else if (cs_rise) begin
         cmd_q <= rx_q;
      end
   end
   // ----------------------------------------
   // fault filters and limiter per channel
   // ----------------------------------------
   logic [13:0] retry_q;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         retry_q <= '0;
      end else if (int'(retry_q) >= RETRY_PERIOD_CYC - 1) begin
         retry_q <= '0;
      end else begin
         retry_q <= retry_q + 14'd1;
      end
   end
   wire retry_win = int'(retry_q) < RON;
   wire [15:0] short_lim = 16'(drv_spi_pkg::SHORT_MIN_CYC * (int'(filter_sel) + 1));
   genvar c;
   generate
      for (c = 0; c < CHANNELS; c++) begin : g_ch
         logic [15:0] cnt_q;
         logic flt_q;
         wire on = cmd_q[c];
         wire cond = on ? short_s2_q[c] : open_s2_q[c];
         always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               cnt_q <= '0;
               flt_q <= 1'b0;
            end else if (!cond) begin
               cnt_q <= '0;
               flt_q <= 1'b0;
            end else if (on ? (cnt_q >= short_lim) : (int'(cnt_q) >= OPEN_OFF_CYC)) begin
               flt_q <= 1'b1;
            end else begin
               cnt_q <= cnt_q + 16'd1;
            end
         end
         assign fault[c] = flt_q;
         assign drive_on[c] = on && (!flt_q || !short_s2_q[c] || retry_win);
      end
   endgenerate
endmodule

// ===== rtl/drv_spi_host.sv
// controller end: ahb-lite slave registers driving one spi frame per go
`timescale 1ns/1ps
module drv_spi_host (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   output logic irq,
   drv_spi_if.host link
);
   localparam int W = drv_spi_pkg::WORD_BITS;
   typedef enum logic [3:0] {
      S_IDLE = 4'b0001, S_LOW = 4'b0010, S_HIGH = 4'b0100, S_GAP = 4'b1000
   } state_t;
   // ----------------------------------------
   // bus slave
   // ----------------------------------------
   logic [15:0] tx_q, rx_q;
   logic [1:0] stat_q, mask_q;
   logic [31:0] a_q;
   logic w_q, busy;
   logic go, done_ev, flt_ev;
   logic rd_req;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         a_q <= '0;
         w_q <= 1'b0;
      end else begin
         a_q <= haddr;
         w_q <= hsel && hready && htrans[1] && hwrite;
      end
   end
   assign rd_req = hsel && hready && htrans[1] && !hwrite;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign go = w_q && a_q == drv_spi_pkg::REG_CTRL && hwdata[drv_spi_pkg::CTRL_GO_BIT] && !busy;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         tx_q <= drv_spi_pkg::TX_RESET;
         mask_q <= drv_spi_pkg::MASK_RESET;
      end else if (w_q && a_q == drv_spi_pkg::REG_TX) begin
         tx_q <= hwdata[15:0];
      end else if (w_q && a_q == drv_spi_pkg::REG_MASK) begin
         mask_q <= hwdata[1:0];
      end
   end
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= '0;
      end else if (rd_req) begin
         unique case (haddr)
            drv_spi_pkg::REG_TX: hrdata <= {16'h0000, tx_q};
            drv_spi_pkg::REG_RX: hrdata <= {16'h0000, rx_q};
            drv_spi_pkg::REG_CTRL: hrdata <= {31'h0000_0000, busy};
            drv_spi_pkg::REG_STAT: hrdata <= {30'h0000_0000, stat_q};
            drv_spi_pkg::REG_MASK: hrdata <= {30'h0000_0000, mask_q};
            default: hrdata <= '0;
         endcase
      end
   end
   // status read clears, but a new event in that cycle still sets
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         stat_q <= 2'b00;
      end else begin
         stat_q <= ((rd_req && haddr == drv_spi_pkg::REG_STAT) ? 2'b00 : stat_q)
                   | {flt_ev, done_ev};
      end
   end
   // hrdata loads at the address phase, so it stands through the data phase
   assign irq = |(stat_q & mask_q);
   // ----------------------------------------
   // link engine
   // ----------------------------------------
   state_t st_q;
   logic [2:0] div_q;
   logic [4:0] bit_q;
   logic [15:0] sh_q;
   logic [1:0] so_s_q;
   logic [3:0] gap_q;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         so_s_q <= 2'b11;
      end else begin
         so_s_q <= {so_s_q[0], link.so};
      end
   end
   assign busy = st_q != S_IDLE;
   wire tick = div_q == 3'(drv_spi_pkg::HALF_SCLK_CYC - 1);
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         div_q <= '0;
      end else if (st_q == S_IDLE || tick) begin
         div_q <= '0;
      end else begin
         div_q <= div_q + 3'd1;
      end
   end
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_q <= S_IDLE;
         link.cs_n <= 1'b1;
         link.sclk <= 1'b0;
         link.si <= 1'b0;
         sh_q <= '0;
         bit_q <= '0;
         gap_q <= '0;
         rx_q <= '0;
         done_ev <= 1'b0;
      end else begin
         done_ev <= 1'b0;
         unique case (st_q)
            S_IDLE: if (go) begin
               link.cs_n <= 1'b0;
               link.si <= tx_q[W-1];
               sh_q <= tx_q;
               bit_q <= '0;
               st_q <= S_LOW;
            end
            S_LOW: if (tick) begin
               if (int'(bit_q) == W) begin
                  link.cs_n <= 1'b1;
                  rx_q <= sh_q;
                  done_ev <= 1'b1;
                  gap_q <= '0;
                  st_q <= S_GAP;
               end else begin
                  link.sclk <= 1'b1;
                  st_q <= S_HIGH;
               end
            end
            S_HIGH: if (tick) begin
               link.sclk <= 1'b0;
               sh_q <= {sh_q[W-2:0], so_s_q[1]};
               link.si <= sh_q[W-2];
               bit_q <= bit_q + 5'd1;
               st_q <= S_LOW;
            end
            S_GAP: begin
               gap_q <= gap_q + 4'd1;
               if (int'(gap_q) >= drv_spi_pkg::STR_CYC) begin
                  st_q <= S_IDLE;
               end
            end
         endcase
      end
   end
   assign flt_ev = done_ev && (rx_q != 16'h0000);
endmodule

// ===== tb/drv_spi_link_sva.sv
// checker for the four-wire link between controller and driver
`timescale 1ns/1ps
module drv_spi_link_sva (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic cs_n,
   input wire logic sclk,
   input wire logic si,
   input wire logic so_o,
   input wire logic so_oe,
   input wire logic so
);
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // ----------------------------------------
   // helper: clock rises seen in one frame
   // ----------------------------------------
   logic [7:0] edges_q;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         edges_q <= 8'h00;
      end else if (cs_n) begin
         edges_q <= 8'h00;
      end else if ($rose(sclk)) begin
         edges_q <= edges_q + 8'h01;
      end
   end
   // ----------------------------------------
   // sequences and assertions
   // ----------------------------------------
   // select synchroniser costs up to five cycles
   sequence out_on_s;
      ##[1:5] so_oe;
   endsequence
   sequence out_off_s;
      ##[1:5] !so_oe;
   endsequence
   sequence sel_gap_s;
      cs_n[*8] ##1 cs_n[*2];
   endsequence
   AST_SEL_FALL_OPENS: assert property ($fell(cs_n) |-> out_on_s)
      else $error("output not enabled after select fall");
   AST_SEL_RISE_CLOSES: assert property ($rose(cs_n) |-> out_off_s)
      else $error("output not released after select rise");
   AST_IDLE_RELEASED: assert property (cs_n[*6] |-> !so_oe && so)
      else $error("output driven while deselected");
   AST_OUT_MOVES_LOW: assert property (so_oe && $changed(so_o) |-> !sclk)
      else $error("status bit moved while clock high");
   AST_IN_STABLE_HIGH: assert property (!cs_n && $changed(si) |-> !sclk)
      else $error("serial input moved while clock high");
   AST_SEL_CLOCK_LOW: assert property ($changed(cs_n) |-> !sclk && !$past(sclk))
      else $error("select moved while clock high");
   AST_FRAME_BITS: assert property ($rose(cs_n) |-> edges_q == 8'h10)
      else $error("frame did not carry sixteen bits");
   AST_FRAME_GAP: assert property ($rose(cs_n) |-> sel_gap_s)
      else $error("frames closer than one microsecond");
endmodule

// ===== tb/driver_spi_command_status_port_tb.sv
// self-checking bench: controller and driver joined over the link
`timescale 1ns/1ps
module driver_spi_command_status_port_tb;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0000_0000;
   logic [1:0] htrans = 2'b00;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'b010;
   logic [31:0] hwdata = 32'h0000_0000;
   logic [31:0] hrdata;
   logic hready;
   logic hresp;
   logic irq;
   logic [7:0] open_raw = 8'h00;
   logic [7:0] short_raw = 8'h00;
   logic [4:0] filter_sel = 5'h01;
   int n_on;
   logic [7:0] drive_on;
   logic [7:0] fault;
   logic [31:0] rd;
   logic [31:0] addrs [5] = '{32'h0000_0000, 32'h0000_0004, 32'h0000_000C,
      32'h0000_0010, 32'h0000_0014};
   int n_errors = 0;
   int n_compared = 0;
   drv_spi_if link();
   always #50 hclk = ~hclk;
   drv_spi_host drv_spi_host_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hrdata(hrdata), .hreadyout(hready), .hresp(hresp), .irq(irq), .link(link));
   drv_spi_device #(.CHANNELS(8), .OPEN_OFF_CYC(50), .RETRY_PERIOD_CYC(200))
      drv_spi_device_inst (.hclk(hclk), .hresetn(hresetn), .link(link), .short_raw(short_raw),
      .open_raw(open_raw), .filter_sel(filter_sel), .drive_on(drive_on), .fault(fault));
   drv_spi_link_sva drv_spi_link_sva_inst (.hclk(hclk), .hresetn(hresetn), .cs_n(link.cs_n),
      .sclk(link.sclk), .si(link.si), .so_o(link.so_o), .so_oe(link.so_oe), .so(link.so));
   // ----------------------------------------
   // tasks
   // ----------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_errors++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // read data taken at the data phase edge; hsel stays up, htrans idles
   task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'b10;
      hwrite <= wr;
      @(posedge hclk);
      while (!hready) @(posedge hclk);
      htrans <= 2'b00;
      hwdata <= d;
      @(posedge hclk);
      while (!hready) @(posedge hclk);
      rd = hrdata;
   endtask
   task automatic frame(input logic [15:0] cmd);
      int i;
      i = 0;
      bus(1'b1, drv_spi_pkg::REG_TX, {16'h0000, cmd});
      bus(1'b1, drv_spi_pkg::REG_CTRL, 32'h0000_0001);
      rd = 32'h0000_0001;
      while (rd[0] !== 1'b0 && i < 400) begin
         bus(1'b0, drv_spi_pkg::REG_CTRL, 32'h0000_0000);
         i++;
      end
      check({31'h0000_0000, rd[0]}, 32'h0000_0000);
      repeat (20) @(posedge hclk);
   endtask
   task automatic final_report;
      $display("compared %0d mismatches %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   // ----------------------------------------
   // tests
   // ----------------------------------------
   initial begin
      #2000000;
      n_errors++;
      final_report();
   end
   initial begin
      repeat (8) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      foreach (addrs[k]) begin
         bus(1'b0, addrs[k], 32'h0000_0000);
         check(rd, 32'h0000_0000);
      end
      check({24'h00_0000, drive_on}, 32'h0000_0000);
      $display("test reset values done");
      bus(1'b1, drv_spi_pkg::REG_MASK, 32'h0000_0001);
      frame(16'hA5C3);
      check({24'h00_0000, drive_on}, 32'h0000_00C3);
      check({31'h0000_0000, irq}, 32'h0000_0001);
      bus(1'b0, drv_spi_pkg::REG_RX, 32'h0000_0000);
      check(rd, 32'h0000_0000);
      bus(1'b0, drv_spi_pkg::REG_STAT, 32'h0000_0000);
      check(rd, 32'h0000_0001);
      bus(1'b0, drv_spi_pkg::REG_STAT, 32'h0000_0000);
      check(rd | {31'h0000_0000, irq}, 32'h0000_0000);
      $display("test command frame done");
      // open filter: quiet before it runs out, flagged after
      open_raw <= 8'h10;
      repeat (20) @(posedge hclk);
      check({24'h00_0000, fault}, 32'h0000_0000);
      repeat (60) @(posedge hclk);
      check({24'h00_0000, fault}, 32'h0000_0010);
      bus(1'b1, drv_spi_pkg::REG_MASK, 32'h0000_0000);
      frame(16'h003C);
      check({24'h00_0000, drive_on}, 32'h0000_003C);
      bus(1'b0, drv_spi_pkg::REG_RX, 32'h0000_0000);
      check(rd, 32'h0000_0010);
      check({31'h0000_0000, irq}, 32'h0000_0000);
      bus(1'b0, drv_spi_pkg::REG_STAT, 32'h0000_0000);
      check(rd, 32'h0000_0003);
      $display("test fault status done");
      // short filter: select one doubles the base step
      short_raw <= 8'h04;
      repeat (400) @(posedge hclk);
      check({24'h00_0000, fault}, 32'h0000_0000);
      repeat (250) @(posedge hclk);
      check({24'h00_0000, fault}, 32'h0000_0004);
      n_on = 0;
      repeat (200) begin
         @(posedge hclk);
         n_on += int'(drive_on[2]);
      end
      check(32'(n_on), 32'h0000_0002);
      $display("test short filter done");
      final_report();
   end
endmodule
